// ---- sfp_regs.svh ----
// Opcodes, status reset value and page geometry for the
// serial flash program/erase sequencer.
// Assumes it is included by bare name from the sequencer top file only.
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ****************************************************
// Opcodes
// ****************************************************
`define SFP_OP_WRITE_ENABLE_CMD   8'h06
`define SFP_OP_READ_STATUS_ONE_CMD  8'h05
`define SFP_OP_READ_STATUS_TWO_CMD  8'h07
`define SFP_OP_PP     8'h02
`define SFP_OP_PP4    8'h12
`define SFP_OP_QPP    8'h32
`define SFP_OP_QPP_B  8'h38
`define SFP_OP_QPP4   8'h34
`define SFP_OP_PSUSP  8'h85
`define SFP_OP_PRESM  8'h8A
`define SFP_OP_SE     8'hD8
`define SFP_OP_SE4    8'hDC

// ****************************************************
// Status fields, geometry and counts
// ****************************************************
`define SFP_ALEN3     14'h0018
`define SFP_ALEN4     14'h0020
`define SFP_OPBITS    14'h0008
`define SFP_CNT_MAX   14'h3FFF
`define SFP_PAGE_LAST 9'h1FF
`define SFP_SECT_LSB  18
`define SFP_SR_RST    8'h00
`define SFP_SYNC_W    11

`endif

// ---- sfp_pkg.sv ----
// Types shared by the sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package sfp_pkg;
  typedef logic [8:0] sfp_idx_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SCAN, ST_RD, ST_WR, ST_SUSP, ST_ERASE
  } sfp_state_e;
endpackage : sfp_pkg

// ---- sfp_sync.sv ----
// Two-flop synchroniser for a bus of slow levels.
// Assumes each bit is a quasi-static level from another domain.
`timescale 1ns/100ps
module sfp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sfp_sync

// ---- sfp_page_buf.sv ----
// 512-byte page buffer: written from the link clock, read
// from the core clock with a registered read port.
// Assumes writes and reads never touch the same byte at once.
`timescale 1ns/100ps
module sfp_page_buf (
  input wire logic wclk,
  input wire logic we,
  input wire sfp_pkg::sfp_idx_t waddr,
  input wire logic [7:0] wdata,
  input wire logic rclk,
  input wire sfp_pkg::sfp_idx_t raddr,
  output logic [7:0] rdata_r
);
  import sfp_pkg::*;
  logic [7:0] mem [0:511];

  // Link side byte store
  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Core side registered read
  always_ff @(posedge rclk) begin
    rdata_r <= mem[raddr];
  end
endmodule : sfp_page_buf

// ---- sfp_top.sv ----
// Program/erase command sequencer of a serial NOR flash.
// Assumes an SPI host in mode 0 on spi_clk and an array
// engine on ref_clk answering each request with arr_ack.
//
// Function
// - Up to one aligned 512-byte page per command
// - Partial ECC unit writes flag ECC off
// - Page program needs write-enable latch set
// - 02h takes 3/4 address bytes, 12h four
// - Data past page end wraps to page start
// - Only bytes sent are programmed
// - Programming only clears bits, never sets
// - Status one shows busy and program error
// - Quad program loads four bits per clock
// - Quad program needs quad enable and latch
// - Suspend acts only while programming runs
// - Status two bit 0 shows program suspended
// - Resume ignored unless program is suspended
// - Resume sets busy and continues programming
// - Reads allowed while programming is suspended
// - Sector erase D8h/DCh sets sector to ones
// - Sector erase needs write-enable latch set
// - Erase only if select rises after address
// - Busy bit reads one during erase
// - Protected sector erase refused, erase error set
`timescale 1ns/100ps
`include "sfp_regs.svh"
module sfp_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_in,
  output logic [3:0] spi_io_out,
  output logic [3:0] spi_io_oe,
  input wire logic extended_address_mode,
  input wire logic quad_enable,
  input wire logic [2:0] block_prot_bits,
  input wire logic [255:0] persistent_sector_lock,
  input wire logic [255:0] dynamic_sector_lock,
  output logic arr_req,
  output logic arr_write,
  output logic arr_erase,
  output logic [31:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic arr_ecc_off,
  input wire logic arr_ack,
  input wire logic arr_fail,
  input wire logic [7:0] arr_rdata,
  output logic [7:0] status_one,
  output logic [7:0] status_two
);
  import sfp_pkg::*;

  // ****************************************************
  // Link domain: frame decode on spi_clk
  // ****************************************************
  logic act_r;
  logic [13:0] bcnt_r;
  logic [2:0] sub_r;
  logic [7:0] op_r;
  logic [31:0] addr_r;
  sfp_idx_t ptr_r;
  logic [7:0] acc_r;
  logic dseen_r;
  logic [511:0] mask_r;
  logic [3:0] io_out_r;
  logic [3:0] io_oe_r;
  logic [10:0] to_link;
  logic [10:0] lsync;
  logic busy_l;
  logic ext_l;
  logic [7:0] sr1_l;
  logic sr2_l;

  // Frame reset: chip select high or device reset
  wire lrst_n = nrst & ~spi_cs_n;

  assign busy_l = lsync[0];
  assign ext_l = lsync[1];
  assign sr1_l = lsync[9:2];
  assign sr2_l = lsync[10];

  // Opcode classes
  wire pp_op = (op_r == `SFP_OP_PP) | (op_r == `SFP_OP_PP4);
  wire q_op = (op_r == `SFP_OP_QPP) | (op_r == `SFP_OP_QPP_B)
            | (op_r == `SFP_OP_QPP4);
  wire se_op = (op_r == `SFP_OP_SE) | (op_r == `SFP_OP_SE4);
  wire prog_op = pp_op | q_op;
  wire four_op = (op_r == `SFP_OP_PP4) | (op_r == `SFP_OP_QPP4)
               | (op_r == `SFP_OP_SE4);
  wire [13:0] alen = (four_op | ext_l) ? `SFP_ALEN4
                                       : `SFP_ALEN3;
  wire [13:0] hdr = `SFP_OPBITS + alen;

  // Position in the frame, zero before the first edge
  wire [13:0] pos = act_r ? bcnt_r : 14'h0000;
  wire [13:0] pos_inc = (pos == `SFP_CNT_MAX) ? pos
                                              : pos + 14'h0001;
  wire in_op = pos < `SFP_OPBITS;
  wire in_addr = !in_op && (pos < hdr);
  wire addr_last = in_addr && (pos == hdr - 14'h0001);
  wire store = !in_op && !in_addr && prog_op && !busy_l;

  // Data byte merge: unsent bits stay one
  wire [7:0] base = (sub_r == 3'h0) ? 8'hFF : acc_r;
  wire [7:0] one_bit = 8'h80 >> sub_r;
  wire [7:0] nb_s = spi_io_in[0] ? base : (base & ~one_bit);
  wire [7:0] nb_q = (sub_r == 3'h0) ? {spi_io_in, base[3:0]}
                                   : {base[7:4], spi_io_in};
  wire [7:0] nb = q_op ? nb_q : nb_s;
  wire byte_end = q_op ? (sub_r == 3'h1) : (sub_r == 3'h7);

  // Frame activity and bit counter, cleared by select
  always_ff @(posedge spi_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      act_r <= 1'b0;
      sub_r <= 3'h0;
    end else begin
      act_r <= 1'b1;
      if (store) begin
        sub_r <= byte_end ? 3'h0 : sub_r + 3'h1;
      end
    end
  end

  // Frame contents kept after select rises
  always_ff @(posedge spi_clk or negedge nrst) begin
    if (!nrst) begin
      bcnt_r <= 14'h0000;
      op_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      ptr_r <= '0;
      acc_r <= 8'hFF;
    end else begin
      bcnt_r <= pos_inc;
      if (in_op) begin
        op_r <= {op_r[6:0], spi_io_in[0]};
      end
      if (pos == 14'h0000) begin
        addr_r <= 32'h0000_0000;
      end else if (in_addr) begin
        addr_r <= {addr_r[30:0], spi_io_in[0]};
      end
      if (addr_last) begin
        ptr_r <= {addr_r[7:0], spi_io_in[0]};
      end else if (store && byte_end) begin
        ptr_r <= ptr_r + 9'h001;
      end
      if (store) begin
        acc_r <= nb;
      end
    end
  end

  // Bytes loaded in this frame; untouched while busy
  // Busy seen by the link is stale until two edges have passed
  always_ff @(posedge spi_clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= '0;
      dseen_r <= 1'b0;
    end else if (pos == 14'h0002 && !busy_l) begin
      mask_r <= '0;
      dseen_r <= 1'b0;
    end else if (store) begin
      mask_r[ptr_r] <= 1'b1;
      dseen_r <= 1'b1;
    end
  end

  // Status read output on the falling edge
  wire rd1 = op_r == `SFP_OP_READ_STATUS_ONE_CMD;
  wire rd2 = op_r == `SFP_OP_READ_STATUS_TWO_CMD;
  wire [7:0] stat = rd1 ? sr1_l : {7'h00, sr2_l};
  wire so_bit = stat[~bcnt_r[2:0]];
  wire so_en = act_r && (bcnt_r >= `SFP_OPBITS) && (rd1 | rd2);

  always_ff @(negedge spi_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else begin
      io_out_r <= {2'b00, so_bit, 1'b0};
      io_oe_r <= {2'b00, so_en, 1'b0};
    end
  end

  assign spi_io_out = io_out_r;
  assign spi_io_oe = io_oe_r;

  // ****************************************************
  // Crossings and page buffer
  // ****************************************************
  logic cs_s;
  logic cs_d_r;
  logic [7:0] buf_q;
  sfp_idx_t idx_r;

  // Core state seen by the link
  sfp_sync #(.W(`SFP_SYNC_W)) u_to_link (
    .clk(spi_clk),
    .rst_n(nrst),
    .d(to_link),
    .q(lsync)
  );

  // Select active seen by the core, low in reset: no false edge
  sfp_sync #(.W(1)) u_cs (
    .clk(ref_clk),
    .rst_n(nrst),
    .d(~spi_cs_n),
    .q(cs_s)
  );

  sfp_page_buf u_buf (
    .wclk(spi_clk),
    .we(store),
    .waddr(ptr_r),
    .wdata(nb),
    .rclk(ref_clk),
    .raddr(idx_r),
    .rdata_r(buf_q)
  );

  // ****************************************************
  // Core domain: command execution on ref_clk
  // ****************************************************
  sfp_state_e state_r;
  sfp_state_e st_nxt;
  logic wel_r;
  logic wel_nxt;
  logic perr_r;
  logic perr_nxt;
  logic eerr_r;
  logic eerr_nxt;
  logic ps_r;
  logic ps_nxt;
  logic sp_r;
  logic sp_nxt;
  logic busy_r;
  sfp_idx_t idx_nxt;
  logic [31:0] base_r;
  logic [31:0] base_nxt;
  logic req_nxt;
  logic wr_nxt;
  logic er_nxt;
  logic [31:0] aa_nxt;
  logic [7:0] wd_nxt;
  logic eo_nxt;

  // Frame end: select risen, link frozen
  wire commit = cs_d_r & ~cs_s;
  wire [31:0] addr_c = (four_op | extended_address_mode) ? addr_r
                     : {8'h00, addr_r[23:0]};
  wire [7:0] sect = addr_c[`SFP_SECT_LSB +: 8];
  wire [3:0] bp_sh = {1'b0, block_prot_bits} + 4'h1;
  wire bp_hit = (block_prot_bits == 3'h7)
              || ((block_prot_bits != 3'h0)
              && ((sect >> bp_sh) == (8'hFF >> bp_sh)));
  wire prot = bp_hit | persistent_sector_lock[sect]
            | dynamic_sector_lock[sect];
  wire ok_prog = wel_r && dseen_r
               && (pp_op || (q_op && quad_enable));
  wire ok_er = wel_r && (bcnt_r == hdr);
  wire running = (state_r == ST_SCAN) || (state_r == ST_RD)
              || (state_r == ST_WR);
  wire idx_end = idx_r == `SFP_PAGE_LAST;
  wire unit_full = &mask_r[{idx_r[8:4], 4'h0} +: 16];
  wire operation_in_progress = (st_nxt != ST_IDLE) && (st_nxt != ST_SUSP); // Aligned with state

  // Next-state logic of the sequencer
  always_comb begin
    st_nxt = state_r;
    wel_nxt = wel_r;
    perr_nxt = perr_r;
    eerr_nxt = eerr_r;
    ps_nxt = ps_r;
    idx_nxt = idx_r;
    base_nxt = base_r;
    req_nxt = 1'b0;
    wr_nxt = arr_write;
    er_nxt = arr_erase;
    aa_nxt = arr_addr;
    wd_nxt = arr_wdata;
    eo_nxt = arr_ecc_off;
    sp_nxt = sp_r | (commit && running
           && (op_r == `SFP_OP_PSUSP));
    case (state_r)
      ST_IDLE: begin
        if (commit && op_r == `SFP_OP_WRITE_ENABLE_CMD) begin
          wel_nxt = 1'b1;
        end else if (commit && prog_op) begin
          if (ok_prog) begin
            st_nxt = ST_SCAN;
            idx_nxt = '0;
            base_nxt = {addr_c[31:9], 9'h000};
            perr_nxt = 1'b0;
          end else begin
            wel_nxt = 1'b0;
          end
        end else if (commit && se_op) begin
          if (ok_er && !prot) begin
            st_nxt = ST_ERASE;
            req_nxt = 1'b1;
            er_nxt = 1'b1;
            wr_nxt = 1'b0;
            aa_nxt = addr_c;
            eerr_nxt = 1'b0;
          end else begin
            eerr_nxt = eerr_r | (ok_er && prot);
            wel_nxt = 1'b0;
          end
        end
      end
      ST_SCAN: begin
        if (sp_r) begin
          st_nxt = ST_SUSP;
          sp_nxt = 1'b0;
          ps_nxt = 1'b1;
        end else if (mask_r[idx_r]) begin
          st_nxt = ST_RD;
          req_nxt = 1'b1;
          wr_nxt = 1'b0;
          er_nxt = 1'b0;
          aa_nxt = base_r | {23'h00_0000, idx_r};
        end else if (idx_end) begin
          st_nxt = ST_IDLE;
          sp_nxt = 1'b0;
          wel_nxt = 1'b0;
        end else begin
          idx_nxt = idx_r + 9'h001;
        end
      end
      ST_RD: begin
        if (arr_ack) begin
          st_nxt = ST_WR;
          req_nxt = 1'b1;
          wr_nxt = 1'b1;
          wd_nxt = arr_rdata & buf_q;
          eo_nxt = !unit_full;
        end
      end
      ST_WR: begin
        if (arr_ack && (arr_fail || idx_end)) begin
          st_nxt = ST_IDLE;
          perr_nxt = perr_r | arr_fail;
          sp_nxt = 1'b0;
          wel_nxt = 1'b0;
        end else if (arr_ack) begin
          st_nxt = ST_SCAN;
          idx_nxt = idx_r + 9'h001;
        end
      end
      ST_SUSP: begin
        if (commit && op_r == `SFP_OP_PRESM) begin
          st_nxt = ST_SCAN;
          ps_nxt = 1'b0;
        end
      end
      ST_ERASE: begin
        if (arr_ack) begin
          st_nxt = ST_IDLE;
          eerr_nxt = eerr_r | arr_fail;
          wel_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cs_d_r <= 1'b0;
      wel_r <= 1'b0;
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
      ps_r <= 1'b0;
      sp_r <= 1'b0;
      idx_r <= '0;
      base_r <= 32'h0000_0000;
    end else begin
      state_r <= st_nxt;
      cs_d_r <= cs_s;
      wel_r <= wel_nxt;
      perr_r <= perr_nxt;
      eerr_r <= eerr_nxt;
      ps_r <= ps_nxt;
      sp_r <= sp_nxt;
      idx_r <= idx_nxt;
      base_r <= base_nxt;
    end
  end

  // Array request and status outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arr_req <= 1'b0;
      arr_write <= 1'b0;
      arr_erase <= 1'b0;
      arr_addr <= 32'h0000_0000;
      arr_wdata <= 8'hFF;
      arr_ecc_off <= 1'b0;
      status_one <= `SFP_SR_RST;
      status_two <= `SFP_SR_RST;
      busy_r <= 1'b0;
    end else begin
      arr_req <= req_nxt;
      arr_write <= wr_nxt;
      arr_erase <= er_nxt;
      arr_addr <= aa_nxt;
      arr_wdata <= wd_nxt;
      arr_ecc_off <= eo_nxt;
      status_one <= {1'b0, perr_nxt, eerr_nxt, block_prot_bits,
                     wel_nxt, operation_in_progress};
      status_two <= {7'h00, ps_nxt};
      busy_r <= st_nxt != ST_IDLE;
    end
  end

  // Registered state and extended_address_mode handed to the link
  assign to_link = {status_two[0], status_one,
                    extended_address_mode, busy_r};
endmodule : sfp_top

// ---- sfp_checker.sv ----
// Port assertions for the program/erase sequencer.
// Assumes it is bound to sfp_top; all checks on ref_clk.
`timescale 1ns/100ps
module sfp_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_oe,
  input wire logic [255:0] persistent_sector_lock,
  input wire logic [255:0] dynamic_sector_lock,
  input wire logic arr_req,
  input wire logic arr_write,
  input wire logic arr_erase,
  input wire logic [31:0] arr_addr,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two
);
  // ****************************************
  // Relations between requests and status
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic [7:0] sec = arr_addr[25:18];
  chk_req_busy: assert property (arr_req |-> status_one[0])
    else $error("array request while not busy");
  chk_erase_free: assert property (arr_req && arr_erase |->
    !persistent_sector_lock[sec] && !dynamic_sector_lock[sec])
    else $error("erase issued on locked sector");
  chk_susp_idle: assert property (status_two[0] |-> !status_one[0])
    else $error("busy while suspended");
  chk_susp_quiet: assert property (status_two[0] |-> !arr_req)
    else $error("array request while suspended");
  chk_st2_rsvd: assert property (status_two[7:1] == 7'h00)
    else $error("reserved status two bits set");
  chk_wel_drop: assert property ($fell(status_one[0]) && arr_erase
    |-> ##[0:3] !status_one[1])
    else $error("latch kept after erase");
  chk_req_pulse: assert property (arr_req |=> !arr_req)
    else $error("request longer than one cycle");
  chk_req_kind: assert property (arr_req |-> !(arr_write && arr_erase))
    else $error("write and erase together");
  chk_oe_idle: assert property (spi_cs_n && $past(spi_cs_n)
    |-> spi_io_oe == 4'h0)
    else $error("output driven while deselected");
  chk_erase_busy: assert property (arr_req && arr_erase
    |-> status_one[0] [*2])
    else $error("busy low during erase");
  cov_erase: cover property (arr_req && arr_erase);
  cov_write: cover property (arr_req && arr_write);
  cov_susp: cover property ($rose(status_two[0]));
endmodule : sfp_checker
bind sfp_top sfp_checker chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .spi_cs_n(spi_cs_n), .spi_io_oe(spi_io_oe),
  .persistent_sector_lock(persistent_sector_lock),
  .dynamic_sector_lock(dynamic_sector_lock), .arr_req(arr_req),
  .arr_write(arr_write), .arr_erase(arr_erase), .arr_addr(arr_addr),
  .status_one(status_one), .status_two(status_two));

// ---- sfp_spi_host.sv ----
// SPI host model in mode 0 with a 30 ns clock.
// Assumes the bench fills dat before calling frame.
`timescale 1ns/100ps
module sfp_spi_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic [3:0] spi_io_in,
  input wire logic [3:0] spi_io_out
);
  // ****************************************
  // Frame drivers
  // ****************************************
  logic [7:0] dat [0:511];
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_io_in = 4'h5;
  end
  // Data changes on the falling edge, clock idles low
  task automatic bit_out(input logic [3:0] b);
    spi_io_in = b;
    #15 spi_clk = 1'b1;
    #15 spi_clk = 1'b0;
  endtask : bit_out
  // Opcode, address bits, data bytes, then xb stray bits
  task automatic frame(input logic [7:0] op, input logic [31:0] a,
    input int alen, input int n, input logic q, input int xb);
    int i;
    spi_cs_n = 1'b0;
    #7;
    for (i = 7; i >= 0; i--) bit_out({3'h0, op[i]});
    for (i = alen - 1; i >= 0; i--) bit_out({3'h0, a[i]});
    for (i = 0; i < n; i++) begin
      if (q) begin
        bit_out(dat[i][7:4]);
        bit_out(dat[i][3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) bit_out({3'h0, dat[i][j]});
      end
    end
    repeat (xb) bit_out(4'h0);
    #7 spi_cs_n = 1'b1;
    spi_io_in = ~spi_io_in; // Released lanes show no stale value
    #100;
  endtask : frame
  // Status read, sampled just before each rising edge
  task automatic rd(input logic [7:0] op, output logic [7:0] v);
    int i;
    spi_cs_n = 1'b0;
    #7;
    for (i = 7; i >= 0; i--) bit_out({3'h0, op[i]});
    for (i = 7; i >= 0; i--) begin
      #14 v[i] = spi_io_out[1];
      #1 spi_clk = 1'b1;
      #15 spi_clk = 1'b0;
    end
    #7 spi_cs_n = 1'b1;
    #100;
  endtask : rd
endmodule : sfp_spi_host

// ---- spi_flash_program_erase_cmds_tb.sv ----
// Self-checking bench: SPI host model, array model, checks.
// Assumes sfp_top, sfp_spi_host and the bound checker.
`timescale 1ns/100ps
module spi_flash_program_erase_cmds_tb;
  // ****************************************
  // Signals, clocks and models
  // ****************************************
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic spi_clk, spi_cs_n, arr_req, arr_write, arr_erase, arr_ecc_off;
  logic [3:0] spi_io_in, spi_io_out, spi_io_oe;
  logic ext = 1'b0, qen = 1'b0, arr_ack = 1'b0, arr_fail = 1'b0;
  logic fail_en = 1'b0, ecc_seen = 1'b0;
  logic [2:0] bp = 3'h0;
  logic [255:0] plock = '0, dlock = '0;
  logic [31:0] arr_addr, r, seed = 32'he86f_f8ba;
  logic [7:0] arr_wdata, status_one, status_two, v, arr_rdata = 8'h00;
  logic [7:0] mem [0:1023];
  logic [7:0] exp_m [0:1023];
  int errors = 0, tests_run = 0, k;
  always #5 ref_clk = ~ref_clk;
  sfp_spi_host host_u (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_io_in(spi_io_in), .spi_io_out(spi_io_out));
  sfp_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_io_in(spi_io_in), .spi_io_out(spi_io_out),
    .spi_io_oe(spi_io_oe), .extended_address_mode(ext),
    .quad_enable(qen), .block_prot_bits(bp),
    .persistent_sector_lock(plock), .dynamic_sector_lock(dlock),
    .arr_req(arr_req), .arr_write(arr_write), .arr_erase(arr_erase),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_ecc_off(arr_ecc_off),
    .arr_ack(arr_ack), .arr_fail(arr_fail), .arr_rdata(arr_rdata),
    .status_one(status_one), .status_two(status_two));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Array engine answering after a random delay
  initial forever begin
    @(posedge ref_clk iff arr_req === 1'b1);
    r = rnd();
    repeat (1 + r[1:0]) @(negedge ref_clk);
    if (arr_erase) foreach (mem[i]) mem[i] = 8'hff;
    else if (arr_write) begin
      mem[arr_addr[9:0]] = arr_wdata;
      ecc_seen = arr_ecc_off;
    end
    arr_rdata = mem[arr_addr[9:0]];
    arr_fail = fail_en;
    arr_ack = 1'b1;
    @(negedge ref_clk);
    arr_ack = 1'b0;
    arr_fail = 1'b0;
  end
  // ****************************************
  // Checking and sequencing tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic idle();
    repeat (8) @(negedge ref_clk);
    for (k = 0; k < 20000 && status_one[0] !== 1'b0; k++) @(negedge ref_clk);
  endtask : idle
  task automatic cmp_mem();
    foreach (mem[i]) chk("array byte", mem[i], exp_m[i]);
  endtask : cmp_mem
  // Random bytes, folded into the image only when accepted
  task automatic load(input logic [31:0] a, input int n, input logic acc);
    logic [9:0] j;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      host_u.dat[i] = r[7:0];
      j = {a[9], 9'(a[8:0] + i)};
      if (acc) exp_m[j] = exp_m[j] & r[7:0];
    end
  endtask : load
  task automatic prog(input logic [7:0] op, input logic [31:0] a,
    input int alen, input int n, input logic q, input logic acc, input int xb);
    host_u.frame(8'h06, 32'h0000_0000, 0, 0, 1'b0, 0);
    load(a, n, acc);
    host_u.frame(op, a, alen, n, q, xb);
    idle();
  endtask : prog
  initial begin
    #800000;
    errors++;
    complete_run();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    foreach (mem[i]) begin
      r = rnd();
      mem[i] = r[7:0];
      exp_m[i] = r[7:0];
    end
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("status one", status_one, 8'h00);
    chk("status two", status_two, 8'h00);
    load(32'h0000_0010, 4, 1'b0);
    host_u.frame(8'h02, 32'h0000_0010, 24, 4, 1'b0, 0);
    idle();
    cmp_mem();
    host_u.frame(8'h06, 32'h0000_0000, 0, 0, 1'b0, 0);
    repeat (8) @(negedge ref_clk);
    chk("latch", status_one[1], 1'b1);
    prog(8'h02, 32'h0000_01f8, 24, 20, 1'b0, 1'b1, 0);
    chk("latch", status_one[1], 1'b0);
    cmp_mem();
    prog(8'h12, 32'h0000_0235, 32, 1, 1'b0, 1'b1, 0);
    chk("ecc off", ecc_seen, 1'b1);
    prog(8'h02, 32'h0000_0240, 24, 16, 1'b0, 1'b1, 0);
    chk("ecc off", ecc_seen, 1'b0);
    ext = 1'b1;
    prog(8'h02, 32'h0000_0300, 32, 8, 1'b0, 1'b1, 0);
    fail_en = 1'b1;
    prog(8'h02, 32'h0000_0080, 32, 1, 1'b0, 1'b1, 0);
    fail_en = 1'b0;
    chk("program error", status_one[6], 1'b1);
    prog(8'h32, 32'h0000_0100, 32, 8, 1'b1, 1'b0, 0);
    chk("latch", status_one[1], 1'b0);
    qen = 1'b1;
    ext = 1'b0;
    prog(8'h32, 32'h0000_0100, 24, 16, 1'b1, 1'b1, 0);
    prog(8'h38, 32'h0000_0110, 24, 5, 1'b1, 1'b1, 0);
    prog(8'h34, 32'h0000_0120, 32, 16, 1'b1, 1'b1, 0);
    chk("program error", status_one[6], 1'b0);
    cmp_mem();
    host_u.frame(8'h06, 32'h0000_0000, 0, 0, 1'b0, 0);
    load(32'h0000_0000, 200, 1'b1);
    host_u.frame(8'h02, 32'h0000_0000, 24, 200, 1'b0, 0);
    host_u.frame(8'h85, 32'h0000_0000, 0, 0, 1'b0, 0);
    repeat (30) @(negedge ref_clk);
    chk("suspended", status_two[0], 1'b1);
    host_u.rd(8'h05, v);
    chk("status one read", v[0], 1'b0);
    host_u.rd(8'h07, v);
    chk("status two read", v[0], 1'b1);
    host_u.frame(8'h8a, 32'h0000_0000, 0, 0, 1'b0, 0);
    repeat (8) @(negedge ref_clk);
    chk("busy", status_one[0], 1'b1);
    idle();
    chk("suspended", status_two[0], 1'b0);
    host_u.frame(8'h8a, 32'h0000_0000, 0, 0, 1'b0, 0);
    repeat (8) @(negedge ref_clk);
    chk("busy", status_one[0], 1'b0);
    cmp_mem();
    dlock[0] = 1'b1;
    prog(8'hd8, 32'h0000_0000, 24, 0, 1'b0, 1'b0, 0);
    chk("erase error", status_one[5], 1'b1);
    dlock[0] = 1'b0;
    bp = 3'h7;
    prog(8'hdc, 32'h0000_0000, 32, 0, 1'b0, 1'b0, 0);
    chk("erase error", status_one[5], 1'b1);
    bp = 3'h0;
    prog(8'hd8, 32'h0000_0000, 24, 0, 1'b0, 1'b0, 1);
    chk("latch", status_one[1], 1'b0);
    cmp_mem();
    prog(8'hdc, 32'h0000_0000, 32, 0, 1'b0, 1'b0, 0);
    foreach (exp_m[i]) exp_m[i] = 8'hff;
    chk("erase error", status_one[5], 1'b0);
    cmp_mem();
    complete_run();
  end
endmodule : spi_flash_program_erase_cmds_tb
